// ---- design/pcr_pkg.sv ----
package pcr_pkg;

	// command / status dword in config space
	localparam logic [9:0] PCR_CMD_DW_IDX = 10'h001;
	localparam logic [11:0] PCR_CMD_OFFSET = 12'h004;
	localparam logic [11:0] PCR_STATUS_OFFSET = 12'h006;
	localparam int PCR_REG_W = 16;

	// command bit positions
	localparam int PCR_CMD_IO_EN = 0;
	localparam int PCR_CMD_MEM_EN = 1;
	localparam int PCR_CMD_BUS_MASTER = 2;
	localparam int PCR_CMD_PERR_RESP = 6;
	localparam int PCR_CMD_SERR_EN = 8;
	localparam int PCR_CMD_INTX_DIS = 10;

	// writable command bits; all others read as zero
	localparam logic [15:0] PCR_CMD_WMASK = 16'h0547;
	localparam logic [15:0] PCR_CMD_RESET = 16'h0000;

	// status bit positions
	localparam int PCR_STS_CAP_LIST = 4;
	localparam int PCR_STS_MDPE = 8;
	localparam int PCR_STS_SSE = 14;
	localparam logic [15:0] PCR_STS_FIXED = 16'h0010;

	// strap settle count after reset release
	localparam logic [1:0] PCR_STRAP_SETTLE = 2'h3;

	// receive buffer
	localparam int PCR_DATA_W = 32;
	localparam int PCR_FIFO_DEPTH = 16;

endpackage : pcr_pkg

// ---- design/pcr_command_core.sv ----
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// generic fifo with registered head and registered ready
module pcr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
		logic in_rdy;
		logic out_valid;
		logic [WIDTH-1:0] out_data;
	} pcr_fifo_s;

	pcr_fifo_s st_reg;
	pcr_fifo_s st_next;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		return (p == LAST_C) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	always_comb begin
		st_next = st_reg;
		if (st_reg.out_valid && out_ready_i) begin
			st_next.out_valid = 1'b0;
		end
		// refill head from storage
		if (!st_next.out_valid && st_reg.cnt != '0) begin
			st_next.out_data = st_reg.mem[st_reg.rd];
			st_next.out_valid = 1'b1;
			st_next.rd = ptr_inc(st_reg.rd);
			st_next.cnt = st_next.cnt - 1'b1;
		end
		if (in_valid_i && st_reg.in_rdy) begin
			st_next.mem[st_reg.wr] = in_data_i;
			st_next.wr = ptr_inc(st_reg.wr);
			st_next.cnt = st_next.cnt + 1'b1;
		end
		st_next.in_rdy = (st_next.cnt < DEPTH_C);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign in_ready_o = st_reg.in_rdy;
	assign out_valid_o = st_reg.out_valid;
	assign out_data_o = st_reg.out_data;

endmodule : pcr_fifo

////////////////////////////////////////////////////////////////////////////////
module pcr_command_core
	import pcr_pkg::*;
#(
	parameter int DATA_W = PCR_DATA_W,
	parameter int FIFO_DEPTH = PCR_FIFO_DEPTH
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// mode strap, high selects root port
	input wire logic root_port_i,
	output logic root_mode_o,
	output logic mode_valid_o,
	// configuration requests from the link
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [9:0] cfg_dw_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_rd_ack_o,
	output logic [15:0] cmd_o,
	// device control input
	input wire logic ur_report_en_i,
	// inbound requests from the link
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	input wire logic [DATA_W-1:0] rx_data_i,
	input wire logic rx_io_i,
	input wire logic rx_mem_i,
	input wire logic rx_np_i,
	input wire logic rx_bar_match_i,
	// inbound requests to the user
	output logic usr_rx_valid_o,
	input wire logic usr_rx_ready_i,
	output logic [DATA_W-1:0] usr_rx_data_o,
	output logic usr_rx_bar_hit_o,
	// unsupported request answers
	output logic cpl_ur_o,
	output logic ur_status_set_o,
	// outbound stream from the user
	input wire logic usr_tx_valid_i,
	output logic usr_tx_ready_o,
	input wire logic [DATA_W-1:0] usr_tx_data_i,
	// outbound stream to the link
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [DATA_W-1:0] tx_data_o,
	// error reporting
	input wire logic err_fatal_i,
	input wire logic err_nonfatal_i,
	input wire logic int_err_i,
	input wire logic int_err_fatal_i,
	input wire logic poison_cpl_rx_i,
	input wire logic poison_wr_tx_i,
	output logic err_msg_o,
	output logic err_msg_fatal_o,
	output logic msg_ind_o,
	output logic msg_ind_fatal_o,
	// legacy interrupt
	input wire logic intx_req_i,
	output logic intx_msg_o
);

	typedef struct packed {
		logic strap_s1;
		logic strap_s2;
		logic [1:0] settle;
		logic locked;
		logic root;
		logic [15:0] cmd;
		logic mdpe;
		logic sse;
		logic [31:0] rdata;
		logic rd_ack;
		logic cpl_ur;
		logic ur_set;
		logic tx_valid;
		logic [DATA_W-1:0] tx_data;
		logic tx_rdy;
		logic err_msg;
		logic err_fatal;
		logic msg_ind;
		logic msg_fatal;
		logic intx;
	} pcr_core_s;

	pcr_core_s st_reg;
	pcr_core_s st_next;

	logic fifo_in_ready;
	logic fifo_push;
	logic [DATA_W:0] fifo_in_data;
	logic [DATA_W:0] fifo_out_data;

	// byte-lane merge for a 16-bit half
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0] be
	);
		logic [15:0] r;
		r = old_v;
		if (be[0]) begin
			r[7:0] = new_v[7:0];
		end
		if (be[1]) begin
			r[15:8] = new_v[15:8];
		end
		return r;
	endfunction : lane_merge

	////////////////////////////////////////////////////////////////////////////
	// combinational next state
	logic cmd_hit;
	logic rx_take;
	logic bar_hit;
	logic target_ok;
	logic err_req;
	logic err_req_fatal;
	logic [15:0] status_v;

	always_comb begin
		st_next = st_reg;
		cmd_hit = (cfg_dw_addr_i == PCR_CMD_DW_IDX);
		status_v = PCR_STS_FIXED;
		status_v[PCR_STS_MDPE] = st_reg.mdpe;
		status_v[PCR_STS_SSE] = st_reg.sse;

		st_next.strap_s1 = root_port_i;
		st_next.strap_s2 = st_reg.strap_s1;
		if (!st_reg.locked) begin
			st_next.root = st_reg.strap_s2;
			if (st_reg.settle == PCR_STRAP_SETTLE) begin
				st_next.locked = 1'b1;
			end else begin
				st_next.settle = st_reg.settle + 1'b1;
			end
		end

		if (cfg_wr_i && cmd_hit) begin
			st_next.cmd = lane_merge(st_reg.cmd, cfg_wdata_i[15:0], cfg_be_i[1:0])
				& PCR_CMD_WMASK;
		end

		st_next.rd_ack = cfg_rd_i;
		st_next.rdata = '0;
		if (cfg_rd_i && cmd_hit) begin
			st_next.rdata = {status_v, st_reg.cmd};
		end

		// status clears first so a same-cycle set wins
		if (cfg_wr_i && cmd_hit && cfg_be_i[3]) begin
			if (cfg_wdata_i[PCR_REG_W + PCR_STS_MDPE]) begin
				st_next.mdpe = 1'b0;
			end
			if (cfg_wdata_i[PCR_REG_W + PCR_STS_SSE]) begin
				st_next.sse = 1'b0;
			end
		end

		// parity status gated by response enable
		if (st_reg.cmd[PCR_CMD_PERR_RESP]
			&& (poison_cpl_rx_i || (poison_wr_tx_i && !st_reg.root))) begin
			st_next.mdpe = 1'b1;
		end

		// error message generation
		err_req = err_fatal_i || err_nonfatal_i || (st_reg.root && int_err_i);
		err_req_fatal = err_fatal_i || (st_reg.root && int_err_i && int_err_fatal_i);
		st_next.err_msg = 1'b0;
		st_next.err_fatal = 1'b0;
		// enable gates messages from report port or internal
		if (st_reg.locked && err_req && st_reg.cmd[PCR_CMD_SERR_EN]) begin
			st_next.err_msg = 1'b1;
			st_next.err_fatal = err_req_fatal;
			st_next.sse = 1'b1;
		end

		// internal errors indicated to user in root mode only, regardless of SERR enable
		st_next.msg_ind = st_reg.locked && st_reg.root && int_err_i;
		st_next.msg_fatal = st_reg.locked && st_reg.root && int_err_i && int_err_fatal_i;

		// legacy interrupt only in endpoint mode
		st_next.intx = st_reg.locked && !st_reg.root && intx_req_i
			&& !st_reg.cmd[PCR_CMD_INTX_DIS];

		// inbound target requests
		rx_take = st_reg.locked && rx_valid_i && fifo_in_ready;
		bar_hit = rx_bar_match_i
			&& ((rx_io_i && st_reg.cmd[PCR_CMD_IO_EN])
			|| (rx_mem_i && st_reg.cmd[PCR_CMD_MEM_EN]));
		// bus master gates upstream targets in root mode
		target_ok = st_reg.root
			? (st_reg.cmd[PCR_CMD_BUS_MASTER] || !(rx_io_i || rx_mem_i))
			: bar_hit;
		fifo_push = rx_take && target_ok;
		st_next.cpl_ur = rx_take && !target_ok && rx_np_i;
		st_next.ur_set = rx_take && !target_ok && ur_report_en_i;

		if (st_reg.tx_valid && tx_ready_i) begin
			st_next.tx_valid = 1'b0;
		end
		if (usr_tx_valid_i && st_reg.tx_rdy) begin
			st_next.tx_valid = 1'b1;
			st_next.tx_data = usr_tx_data_i;
		end
		st_next.tx_rdy = !st_next.tx_valid;
	end

	assign fifo_in_data = {bar_hit, rx_data_i};

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
			st_reg.cmd <= PCR_CMD_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive buffer toward the user, held empty until mode locks
	pcr_fifo #(
		.WIDTH(DATA_W + 1),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(ref_clk_i),
		.rst_i(sys_rst_i || !st_reg.locked),
		.in_valid_i(fifo_push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in_data),
		.out_valid_o(usr_rx_valid_o),
		.out_ready_i(usr_rx_ready_i),
		.out_data_o(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign rx_ready_o = fifo_in_ready;
	assign usr_rx_data_o = fifo_out_data[DATA_W-1:0];
	assign usr_rx_bar_hit_o = fifo_out_data[DATA_W];
	assign root_mode_o = st_reg.root;
	assign mode_valid_o = st_reg.locked;
	assign cfg_rdata_o = st_reg.rdata;
	assign cfg_rd_ack_o = st_reg.rd_ack;
	assign cmd_o = st_reg.cmd;
	assign cpl_ur_o = st_reg.cpl_ur;
	assign ur_status_set_o = st_reg.ur_set;
	assign tx_valid_o = st_reg.tx_valid;
	assign tx_data_o = st_reg.tx_data;
	assign usr_tx_ready_o = st_reg.tx_rdy;
	assign err_msg_o = st_reg.err_msg;
	assign err_msg_fatal_o = st_reg.err_fatal;
	assign msg_ind_o = st_reg.msg_ind;
	assign msg_ind_fatal_o = st_reg.msg_fatal;
	assign intx_msg_o = st_reg.intx;

endmodule : pcr_command_core

`default_nettype wire

// ---- verification/pcr_command_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcr_command_core_sva
	import pcr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// mode and command
	input wire logic root_mode_o,
	input wire logic mode_valid_o,
	input wire logic [15:0] cmd_o,
	// inbound
	input wire logic rx_valid_i,
	input wire logic rx_ready_o,
	input wire logic rx_io_i,
	input wire logic rx_mem_i,
	input wire logic rx_np_i,
	input wire logic rx_bar_match_i,
	input wire logic cpl_ur_o,
	// transmit
	input wire logic usr_tx_valid_i,
	input wire logic usr_tx_ready_o,
	input wire logic [31:0] usr_tx_data_i,
	input wire logic tx_valid_o,
	input wire logic [31:0] tx_data_o,
	// events
	input wire logic err_msg_o,
	input wire logic err_fatal_i,
	input wire logic int_err_i,
	input wire logic msg_ind_o,
	input wire logic intx_req_i,
	input wire logic intx_msg_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic take;
	logic drop;
	assign take = rx_valid_i && rx_ready_o && mode_valid_o;
	// request refused by mode and command bits
	assign drop = root_mode_o ? ((rx_io_i || rx_mem_i) && !cmd_o[2])
		: !(rx_bar_match_i && ((rx_io_i && cmd_o[0]) || (rx_mem_i && cmd_o[1])));
	////////////////////////////////////////
	rsv_bits_zero_a: assert property ((cmd_o & ~PCR_CMD_WMASK) == 16'h0000)
		else $error("reserved command bit set");
	ur_on_drop_a: assert property (take && drop |=> cpl_ur_o == $past(rx_np_i))
		else $error("refused request not answered");
	no_ur_pass_a: assert property (take && !drop |=> !cpl_ur_o)
		else $error("accepted request answered as unsupported");
	tx_pass_a: assert property (usr_tx_valid_i && usr_tx_ready_o |=>
		tx_valid_o && tx_data_o == $past(usr_tx_data_i)) else $error("transmit word lost");
	intx_gate_a: assert property (intx_msg_o |->
		$past(intx_req_i) && !$past(cmd_o[10]) && !root_mode_o) else $error("stray intx");
	intx_send_a: assert property (intx_req_i && mode_valid_o && !root_mode_o &&
		!cmd_o[10] |=> intx_msg_o) else $error("intx not sent");
	err_gate_a: assert property (err_msg_o |-> $past(cmd_o[8]))
		else $error("error message without enable");
	err_send_a: assert property (err_fatal_i && mode_valid_o && cmd_o[8] |=> err_msg_o)
		else $error("error message not sent");
	msg_ind_a: assert property (int_err_i && mode_valid_o && root_mode_o |=> msg_ind_o)
		else $error("internal error not indicated");
	mode_hold_a: assert property (mode_valid_o |=> mode_valid_o && $stable(root_mode_o))
		else $error("mode changed");
	cover property (cpl_ur_o);
	cover property (intx_msg_o);
	cover property (msg_ind_o && err_msg_o);
endmodule : pcr_command_core_sva
bind pcr_command_core pcr_command_core_sva u_sva (.*);
`default_nettype wire

// ---- verification/pcr_user_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcr_user_model (
	// clock and command
	input wire logic clk_i,
	input wire logic [15:0] cmd_i,
	input wire logic stall_i,
	// receive sink
	input wire logic rx_valid_i,
	input wire logic [31:0] rx_data_i,
	output logic rx_ready_o,
	// transmit source
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [31:0] tx_data_o
);
	int rx_cnt = 0;
	int err_fwd = 0;
	logic [31:0] rx_last = 32'h0;
	assign rx_ready_o = !stall_i;
	initial begin
		tx_valid_o = 1'b0;
		tx_data_o = 32'h0;
	end
	always @(posedge clk_i) begin
		if (rx_valid_i && rx_ready_o) begin
			rx_cnt <= rx_cnt + 1;
			rx_last <= rx_data_i;
			if (rx_data_i[31:24] == 8'hE0 && cmd_i[8])
				err_fwd <= err_fwd + 1;
		end
	end
	task automatic send(input logic [31:0] w, input logic io, input logic mem);
		int i;
		if ((io && !cmd_i[0]) || (mem && !cmd_i[1]))
			return;
		@(posedge clk_i);
		tx_valid_o <= 1'b1;
		tx_data_o <= w;
		for (i = 0; i < 20; i++) begin
			@(negedge clk_i);
			if (tx_ready_i)
				break;
		end
		@(posedge clk_i);
		tx_valid_o <= 1'b0;
		tx_data_o <= ~w;
	endtask : send
endmodule : pcr_user_model
`default_nettype wire

// ---- verification/pcie_command_reg_behavior_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcie_command_reg_behavior_tb_top;
	import pcr_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic root_port_i = 1'b0;
	logic cfg_wr_i = 1'b0;
	logic cfg_rd_i = 1'b0;
	logic [9:0] cfg_dw_addr_i = 10'h001;
	logic [3:0] cfg_be_i = 4'h0;
	logic [31:0] cfg_wdata_i = 32'h0;
	logic ur_report_en_i = 1'b1;
	logic rx_valid_i = 1'b0;
	logic [31:0] rx_data_i = 32'h0;
	logic [3:0] kind = 4'h0;
	logic [6:0] ev = 7'h00;
	logic tx_ready_i = 1'b1;
	logic stall = 1'b0;
	logic last_hit = 1'b0;
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	int base;
	wire logic rx_io_i, rx_mem_i, rx_np_i, rx_bar_match_i, usr_rx_ready_i, usr_tx_valid_i;
	wire logic intx_req_i, poison_wr_tx_i, poison_cpl_rx_i, int_err_fatal_i, int_err_i;
	wire logic err_nonfatal_i, err_fatal_i, root_mode_o, mode_valid_o, cfg_rd_ack_o;
	wire logic rx_ready_o, usr_rx_valid_o, usr_rx_bar_hit_o, cpl_ur_o, ur_status_set_o;
	wire logic usr_tx_ready_o, tx_valid_o, err_msg_o, err_msg_fatal_o, msg_ind_o;
	wire logic msg_ind_fatal_o, intx_msg_o;
	wire logic [31:0] usr_tx_data_i, cfg_rdata_o, usr_rx_data_o, tx_data_o;
	wire logic [15:0] cmd_o;
	assign {rx_io_i, rx_mem_i, rx_np_i, rx_bar_match_i} = kind;
	assign {intx_req_i, poison_wr_tx_i, poison_cpl_rx_i, int_err_fatal_i, int_err_i,
		err_nonfatal_i, err_fatal_i} = ev;
	pcr_command_core u_dut (.*);
	pcr_user_model u_usr (.clk_i(ref_clk_i), .cmd_i(cmd_o), .stall_i(stall),
		.rx_valid_i(usr_rx_valid_o), .rx_data_i(usr_rx_data_o), .rx_ready_o(usr_rx_ready_i),
		.tx_valid_o(usr_tx_valid_i), .tx_ready_i(usr_tx_ready_o), .tx_data_o(usr_tx_data_i));
	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		if (usr_rx_valid_o && usr_rx_ready_i)
			last_hit <= usr_rx_bar_hit_o;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	task automatic tmo(input int i);
		if (i >= 20) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask : tmo
	task automatic cfg_wr(input logic [3:0] b, input logic [31:0] d);
		@(posedge ref_clk_i);
		cfg_wr_i <= 1'b1;
		cfg_dw_addr_i <= 10'h001;
		cfg_be_i <= b;
		cfg_wdata_i <= d;
		@(posedge ref_clk_i);
		cfg_wr_i <= 1'b0;
	endtask : cfg_wr
	task automatic cmd(input logic [15:0] c);
		cfg_wr(4'h3, {16'h0000, c});
	endtask : cmd
	task automatic cfg_rd(input logic [9:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		cfg_rd_i <= 1'b1;
		cfg_dw_addr_i <= a;
		@(posedge ref_clk_i);
		cfg_rd_i <= 1'b0;
		#1 chk(cfg_rd_ack_o, 1'b1);
		chk(cfg_rdata_o, e);
	endtask : cfg_rd
	task automatic rx(input logic [3:0] k, input logic [31:0] d, input logic [1:0] e);
		int i;
		@(posedge ref_clk_i);
		kind <= k;
		rx_data_i <= d;
		rx_valid_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(negedge ref_clk_i);
			if (rx_ready_o)
				break;
		end
		tmo(i);
		@(posedge ref_clk_i);
		rx_valid_i <= 1'b0;
		rx_data_i <= ~d;
		#1 chk({cpl_ur_o, ur_status_set_o}, e);
		repeat (4) @(posedge ref_clk_i);
		if (e == 2'b00) begin
			chk(u_usr.rx_last, d);
			chk(last_hit, !root_port_i);
		end
	endtask : rx
	task automatic fire(input logic [6:0] v, input logic [4:0] e);
		@(posedge ref_clk_i);
		ev <= v;
		@(posedge ref_clk_i);
		ev <= 7'h00;
		#1 chk({intx_msg_o, err_msg_o, err_msg_fatal_o, msg_ind_o, msg_ind_fatal_o}, e);
	endtask : fire
	task automatic tx(input logic [31:0] w);
		int i;
		u_usr.send(w, 1'b0, 1'b0);
		for (i = 0; i < 20; i++) begin
			@(negedge ref_clk_i);
			if (tx_valid_o)
				break;
		end
		tmo(i);
		chk(tx_data_o, w);
	endtask : tx
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1 chk({mode_valid_o, root_mode_o, usr_tx_ready_o}, 3'b101);
		cfg_rd(10'h001, 32'h0010_0000);
		cfg_rd(10'h002, 32'h0000_0000);
		cmd(16'hFFFF);
		cfg_rd(10'h001, 32'h0010_0547);
		cmd(16'h0000);
		rx(4'hB, 32'h0000_0011, 2'b11);
		rx(4'h7, 32'h0000_0012, 2'b11);
		cmd(16'h0003);
		rx(4'hB, 32'h0000_0013, 2'b00);
		rx(4'h5, 32'h0000_0014, 2'b00);
		rx(4'h6, 32'h0000_0015, 2'b11);
		tx(32'hA5A5_0001);
		cmd(16'h0400);
		fire(7'h40, 5'h00);
		cmd(16'h0000);
		fire(7'h40, 5'h10);
		fire(7'h01, 5'h00);
		fire(7'h10, 5'h00);
		cfg_rd(10'h001, 32'h0010_0000);
		cmd(16'h0140);
		fire(7'h01, 5'h0C);
		fire(7'h02, 5'h08);
		fire(7'h10, 5'h00);
		cfg_rd(10'h001, 32'h4110_0140);
		cfg_wr(4'h8, 32'h4100_0000);
		cfg_rd(10'h001, 32'h0010_0140);
		cmd(16'h0003);
		stall <= 1'b1;
		base = u_usr.rx_cnt;
		n = 0;
		@(posedge ref_clk_i);
		kind <= 4'h5;
		rx_valid_i <= 1'b1;
		repeat (30) begin
			@(negedge ref_clk_i);
			if (rx_ready_o)
				n++;
		end
		@(posedge ref_clk_i);
		rx_valid_i <= 1'b0;
		#1 chk(rx_ready_o, 1'b0);
		chk(n, PCR_FIFO_DEPTH + 1);
		stall <= 1'b0;
		repeat (40) @(posedge ref_clk_i);
		chk(u_usr.rx_cnt, base + n);
		$display("endpoint tests done");
		sys_rst_i <= 1'b1;
		root_port_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1 chk({mode_valid_o, root_mode_o, cmd_o}, {2'b11, 16'h0000});
		rx(4'hB, 32'h0000_0021, 2'b11);
		rx(4'h5, 32'h0000_0022, 2'b01);
		ur_report_en_i <= 1'b0;
		rx(4'hB, 32'h0000_0027, 2'b10);
		ur_report_en_i <= 1'b1;
		rx(4'h3, 32'h0000_0023, 2'b00);
		tx(32'hA5A5_0002);
		cmd(16'h0004);
		rx(4'hB, 32'h0000_0024, 2'b00);
		rx(4'h3, 32'hE000_0025, 2'b00);
		chk(u_usr.err_fwd, 0);
		fire(7'h40, 5'h00);
		fire(7'h04, 5'h02);
		cmd(16'h0100);
		fire(7'h0C, 5'h0F);
		fire(7'h02, 5'h08);
		rx(4'h3, 32'hE000_0026, 2'b00);
		chk(u_usr.err_fwd, 1);
		$display("root port tests done");
		report_and_stop();
	end
endmodule : pcie_command_reg_behavior_tb_top
`default_nettype wire
